// file: common/dcc_pkg.sv
// Types shared by the drain-current controller register bank
`default_nettype none
package dcc_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CAL = 3'b010,
    SEQ_CONV = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic alarm;
    logic conv_done;
    logic cal_done;
  } status_t;
  typedef struct packed {
    logic alu_clear;
    logic fifo_clear;
  } clear_cmd_t;
endpackage
`default_nettype wire

// file: common/dcc_regs.svh
// Register offsets, bit positions and timing constants of the drain-current controller
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_OFF_STATUS 8'h00
`define DCC_OFF_MASK 8'h04
`define DCC_OFF_HWCFG 8'h08
`define DCC_OFF_SWCFG 8'h0C
`define DCC_OFF_CONV 8'h10
`define DCC_OFF_SWCLR 8'h14
`define DCC_OFF_XFER 8'h18
`define DCC_OFF_AMPCAL 8'h1C
`define DCC_OFF_HIGH_VOLTAGE_CAL_BIT 8'h20
`define DCC_OFF_DACIN 8'h24
`define DCC_OFF_DACOUT 8'h2C
`define DCC_OFF_DIRECT 8'h34
`define DCC_OFF_THR 8'h40
`define DCC_OFF_AFLAG 8'h58
`define DCC_OFF_RESULT 8'h5C
`define DCC_OFF_OFFSET 8'h64
`define DCC_OFF_SADDR 8'h6C
`define DCC_CH_STRIDE 8'h04
`define DCC_THR_KINDS 3
`define DCC_WORD_W 16
`define DCC_ADDR_HI 4'h5
`define DCC_BIT_ADC_REFERENCE_SELECT 0
`define DCC_BIT_DAC_REFERENCE_SELECT 1
`define DCC_BIT_CONV 0
`define DCC_CAL_TIME_NS 1000
`define DCC_CLK_PERIOD_NS 5
`define DCC_CAL_CYCLES ((`DCC_CAL_TIME_NS + `DCC_CLK_PERIOD_NS - 1) / `DCC_CLK_PERIOD_NS)
`endif

// file: dv/adc_model.sv
// Behavioural sense converter that answers the register bank's start pulses
`default_nettype none
module adc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adc_start,
  input wire logic slow,
  input wire logic [11:0] v0,
  input wire logic [11:0] v1,
  output logic adc_valid,
  output logic [1:0][11:0] sense_result
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wait_q;
  // Result lines toggle outside the valid cycle, so stale data never matches by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 3'h0;
      adc_valid <= 1'b0;
      sense_result <= '0;
    end else begin
      adc_valid <= 1'b0;
      sense_result <= ~sense_result;
      if (adc_start) begin
        wait_q <= slow ? 3'h6 : 3'h1;
      end else if (wait_q == 3'h1) begin
        wait_q <= 3'h0;
        adc_valid <= 1'b1;
        sense_result <= {v1, v0};
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench of the drain-current controller register bank
`include "dcc_regs.svh"
`default_nettype none
module testbench import dcc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CAL = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] strap = 3'h0;
  logic [1:0] safe_in = 2'h0;
  logic [11:0] v0 = 12'h0;
  logic [11:0] v1 = 12'h0;
  logic slow = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, irq, rerr, adc_ref_internal, dac_ref_internal;
  logic adc_start, adc_valid, alu_clear, fifo_clear;
  logic [6:0] slave_addr;
  logic [1:0] gate_clamp, amp_cal_active, hv_cal;
  logic [1:0][11:0] dac_code, sense_result;
  int fail_count = 0;
  int comparisons = 0;

  always #2.5 pclk = ~pclk;

  drain_current_ctrl_regs #(.CAL_CYCLES(CAL)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .addr_strap_high(strap[2]), .addr_strap_mid(strap[1]), .addr_strap_low(strap[0]), .slave_addr,
    .safe_operation_input(safe_in), .gate_clamp, .adc_ref_internal, .dac_ref_internal, .dac_code,
    .amp_cal_active, .high_voltage_cal_bit(hv_cal), .adc_start, .adc_valid, .sense_result,
    .alu_clear, .fifo_clear
  );

  adc_model i_adc (.pclk, .presetn, .adc_start, .slow, .v0, .v1, .adc_valid, .sense_result);

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer; an extra idle edge keeps back-to-back calls from assigning psel twice
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  function automatic logic [31:0] thr_val(input int i);
    return (i % 3 == 0) ? ((i < 3) ? 32'h100 : 32'h800) : 32'(32'h230 + i);
  endfunction

  task automatic t_addr();
    for (int i = 0; i < 8; i++) begin
      strap <= i[2:0];
      repeat (2) @(posedge pclk);
      chk(32'(slave_addr), {25'h0, 4'h5, i[2:0]});
      rd_chk(`DCC_OFF_SADDR, {25'h0, 4'h5, i[2:0]});
    end
    $display("test strap_address done");
  endtask

  task automatic t_ref();
    rd_chk(`DCC_OFF_HWCFG, 32'h0);
    chk({30'h0, dac_ref_internal, adc_ref_internal}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      apb(1'b1, `DCC_OFF_HWCFG, 32'(i));
      chk({30'h0, dac_ref_internal, adc_ref_internal}, 32'(i));
    end
    apb(1'b1, `DCC_OFF_HWCFG, 32'h0);
    $display("test reference_select done");
  endtask

  task automatic t_thr();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'(`DCC_OFF_THR + 4 * i), thr_val(i) | 32'hFFFF_0000);
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(`DCC_OFF_THR + 4 * i), thr_val(i));
    end
    chk(32'(rerr), 32'h0);
    apb(1'b0, 8'h70, 32'h0);
    chk(32'(rerr), 32'h1);
    $display("test thresholds done");
  endtask

  task automatic t_dac();
    int code;
    apb(1'b1, `DCC_OFF_DACIN, 32'h111);
    apb(1'b1, `DCC_OFF_DACIN + `DCC_CH_STRIDE, 32'h222);
    chk(32'(dac_code), 32'h0);
    apb(1'b1, `DCC_OFF_XFER, 32'h0);
    chk(32'(dac_code), 32'h222111);
    apb(1'b1, `DCC_OFF_DACOUT, 32'h555);
    rd_chk(`DCC_OFF_DACOUT, 32'h111);
    code = (4095 * 400 + 312) / 625;
    apb(1'b1, `DCC_OFF_DIRECT + `DCC_CH_STRIDE, 32'(code));
    chk(32'(dac_code), {8'h0, 12'(code), 12'h111});
    rd_chk(`DCC_OFF_DACIN + `DCC_CH_STRIDE, 32'(code));
    apb(1'b1, `DCC_OFF_DIRECT, 32'h0ABC);
    chk(32'(dac_code), {8'h0, 12'(code), 12'hABC});
    rd_chk(`DCC_OFF_DACIN, 32'h0ABC);
    $display("test dac_load done");
  endtask

  task automatic t_cal();
    int n;
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, `DCC_OFF_AMPCAL, 32'(s));
      n = 0;
      while (amp_cal_active === 2'(s) && n < 20) begin
        n++;
        @(posedge pclk);
      end
      chk(32'(n), 32'(CAL));
    end
    rd_chk(`DCC_OFF_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    apb(1'b1, `DCC_OFF_MASK, 32'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `DCC_OFF_STATUS, 32'h1);
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    $display("test calibration done");
  endtask

  task automatic conv();
    int n;
    apb(1'b1, `DCC_OFF_STATUS, 32'h2);
    apb(1'b1, `DCC_OFF_CONV, 32'h1);
    chk(32'(adc_start), 32'h1);
    n = 0;
    do begin
      apb(1'b0, `DCC_OFF_STATUS, 32'h0);
      n++;
    end while (rdat[1] !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
  endtask

  task automatic t_conv();
    apb(1'b1, `DCC_OFF_HIGH_VOLTAGE_CAL_BIT, 32'h3);
    chk(32'(hv_cal), 32'h3);
    v0 <= 12'h012;
    v1 <= 12'h034;
    conv();
    rd_chk(`DCC_OFF_OFFSET, 32'h012);
    rd_chk(`DCC_OFF_OFFSET + `DCC_CH_STRIDE, 32'h034);
    apb(1'b1, `DCC_OFF_HIGH_VOLTAGE_CAL_BIT, 32'h0);
    v0 <= 12'h200;
    v1 <= 12'h010;
    slow <= 1'b1;
    conv();
    rd_chk(`DCC_OFF_RESULT + `DCC_CH_STRIDE, 32'h010);
    rd_chk(`DCC_OFF_OFFSET, 32'h012);
    rd_chk(`DCC_OFF_AFLAG, 32'h1);
    rd_chk(`DCC_OFF_STATUS, 32'h6);
    $display("test conversion done");
  endtask

  task automatic t_clamp();
    for (int i = 1; i < 5; i++) begin
      safe_in <= 2'(i);
      repeat (2) @(posedge pclk);
      chk(32'(gate_clamp), 32'(i & 3));
    end
    $display("test safe_clamp done");
  endtask

  task automatic t_clear();
    apb(1'b1, `DCC_OFF_SWCLR, 32'h0);
    chk({30'h0, alu_clear, fifo_clear}, 32'h3);
    @(posedge pclk);
    chk({30'h0, alu_clear, fifo_clear}, 32'h0);
    chk(32'(dac_code), 32'h0);
    rd_chk(`DCC_OFF_THR, 32'h0);
    rd_chk(`DCC_OFF_THR + 8'h14, 32'h0);
    rd_chk(`DCC_OFF_AFLAG, 32'h0);
    rd_chk(`DCC_OFF_DACIN, 32'h0);
    rd_chk(`DCC_OFF_MASK, 32'h0);
    rd_chk(`DCC_OFF_STATUS, 32'h0);
    $display("test software_clear done");
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    chk(32'(slave_addr), 32'h28);
    presetn <= 1'b1;
    @(posedge pclk);
    t_addr();
    t_ref();
    t_thr();
    t_dac();
    t_cal();
    t_conv();
    t_clamp();
    t_clear();
    stop_test();
  end
endmodule
`default_nettype wire

// file: rtl/dcc_seq.sv
// Calibration and conversion sequencer of the drain-current controller
`include "dcc_regs.svh"
`default_nettype none
module dcc_seq import dcc_pkg::*; #(
  parameter int CAL_CYCLES = `DCC_CAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic abort,
  input wire logic cal_start,
  input wire logic [1:0] cal_sel,
  input wire logic conv_start,
  input wire logic adc_valid,
  output logic busy,
  output logic [1:0] cal_active,
  output logic adc_start,
  output logic cal_done,
  output logic conv_done
);
  localparam int CW = $clog2(CAL_CYCLES + 1);
  seq_state_t state_q;
  logic [CW-1:0] cnt_q;

  if (CAL_CYCLES < 1) begin : g_chk
    $error("dcc_seq: CAL_CYCLES must be at least one");
  end

  assign busy = (state_q != SEQ_IDLE);

  // A request made while busy is dropped; software polls the busy bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SEQ_IDLE;
      cnt_q <= '0;
      cal_active <= 2'b00;
      adc_start <= 1'b0;
      cal_done <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      cal_done <= 1'b0;
      conv_done <= 1'b0;
      if (abort) begin
        state_q <= SEQ_IDLE;
        cal_active <= 2'b00;
      end else begin
        case (state_q)
          SEQ_IDLE: begin
            if (cal_start && cal_sel != 2'b00) begin // RULE_07
              state_q <= SEQ_CAL;
              cal_active <= cal_sel;
              cnt_q <= CW'(CAL_CYCLES - 1);
            end else if (conv_start) begin
              state_q <= SEQ_CONV;
              adc_start <= 1'b1;
            end
          end
          SEQ_CAL: begin
            if (cnt_q == '0) begin
              state_q <= SEQ_IDLE;
              cal_active <= 2'b00;
              cal_done <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          SEQ_CONV: begin
            if (adc_valid) begin
              state_q <= SEQ_IDLE;
              conv_done <= 1'b1;
            end
          end
          default: state_q <= SEQ_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/drain_current_ctrl_regs.sv
// APB register bank of the two-channel drain-current controller
//
// Notes on behaviour
// RULE_01: Slave address is 0101 plus three straps
// RULE_02: Straps high, mid, low form address bits
// RULE_03: Clear write resets registers, arithmetic unit, FIFO
// RULE_04: Clear also resets thresholds, alarm flags, DACs
// RULE_05: Transfer write copies all inputs to outputs
// RULE_06: Direct write loads channel input and output
// RULE_07: Calibration write starts selected amplifier calibration
// RULE_08: High-voltage cal conversion reports amplifier offset
// RULE_09: Safe input clamps gate; release frees it
// RULE_10: Reference bits pick internal, default external
// RULE_11: Per-channel sense, gate, temperature thresholds
// RULE_12: Host computes direct code from target current
// RULE_13: Each access moves one 16-bit word
`include "dcc_regs.svh"
`default_nettype none
module drain_current_ctrl_regs import dcc_pkg::*; #(
  parameter int DAC_W = 12,
  parameter int ADC_W = 12,
  parameter int CAL_CYCLES = `DCC_CAL_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic addr_strap_high,
  input wire logic addr_strap_mid,
  input wire logic addr_strap_low,
  output logic [6:0] slave_addr,
  input wire logic [1:0] safe_operation_input,
  output logic [1:0] gate_clamp,
  output logic adc_ref_internal,
  output logic dac_ref_internal,
  output logic [1:0][DAC_W-1:0] dac_code,
  output logic [1:0] amp_cal_active,
  output logic [1:0] high_voltage_cal_bit,
  output logic adc_start,
  input wire logic adc_valid,
  input wire logic [1:0][ADC_W-1:0] sense_result,
  output logic alu_clear,
  output logic fifo_clear
);
  if (DAC_W < 1 || DAC_W > `DCC_WORD_W || ADC_W < 1 || ADC_W > `DCC_WORD_W) begin : g_chk
    $error("drain_current_ctrl_regs: widths must lie in 1..16");
  end

  logic [DAC_W-1:0] dac_in_q [2];
  logic [DAC_W-1:0] dac_out_q [2];
  logic [ADC_W-1:0] thr_q [2][`DCC_THR_KINDS];
  logic [ADC_W-1:0] result_q [2];
  logic [ADC_W-1:0] offset_q [2];
  status_t status_q, mask_q, ev;
  clear_cmd_t clr_q;
  logic [1:0] aflag_q;
  logic [`DCC_WORD_W-1:0] swcfg_q;
  logic [`DCC_WORD_W-1:0] rd_d;
  logic hit, wr, rd_setup, swclr, xfer;
  logic seq_busy, seq_cal_done, seq_conv_done;
  logic [1:0] alarm_ev;
  logic conv_take;

  assign rd_setup = psel && !penable;
  // Writes land only at the completing edge of the access phase
  assign wr = psel && penable && pready && pwrite;
  assign swclr = wr && paddr == `DCC_OFF_SWCLR;
  assign xfer = wr && paddr == `DCC_OFF_XFER;
  // Results are caught with the valid pulse; the converter lines move on right after it
  assign conv_take = adc_valid && seq_busy && amp_cal_active == 2'b00;

  // APB answer: one wait-free access phase, data and error set up during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      if (rd_setup) begin
        prdata <= {16'h0000, (pwrite ? 16'h0000 : rd_d)}; // RULE_13
        pslverr <= !hit;
      end
    end
  end

  always_comb begin
    rd_d = '0;
    hit = 1'b1;
    case (paddr)
      `DCC_OFF_STATUS: rd_d = 16'(status_q);
      `DCC_OFF_MASK: rd_d = 16'(mask_q);
      `DCC_OFF_HWCFG: rd_d = 16'({dac_ref_internal, adc_ref_internal});
      `DCC_OFF_SWCFG: rd_d = swcfg_q;
      `DCC_OFF_CONV: rd_d = 16'(seq_busy);
      `DCC_OFF_SWCLR: rd_d = '0;
      `DCC_OFF_XFER: rd_d = '0;
      `DCC_OFF_AMPCAL: rd_d = 16'(amp_cal_active);
      `DCC_OFF_HIGH_VOLTAGE_CAL_BIT: rd_d = 16'(high_voltage_cal_bit);
      `DCC_OFF_AFLAG: rd_d = 16'(aflag_q);
      `DCC_OFF_SADDR: rd_d = 16'(slave_addr);
      default: hit = 1'b0;
    endcase
    for (int c = 0; c < 2; c++) begin
      if (paddr == `DCC_OFF_DACIN + 8'(c * 4)) begin
        rd_d = 16'(dac_in_q[c]);
        hit = 1'b1;
      end
      if (paddr == `DCC_OFF_DACOUT + 8'(c * 4)) begin
        rd_d = 16'(dac_out_q[c]);
        hit = 1'b1;
      end
      if (paddr == `DCC_OFF_DIRECT + 8'(c * 4)) begin
        rd_d = 16'(dac_out_q[c]);
        hit = 1'b1;
      end
      if (paddr == `DCC_OFF_RESULT + 8'(c * 4)) begin
        rd_d = 16'(result_q[c]);
        hit = 1'b1;
      end
      if (paddr == `DCC_OFF_OFFSET + 8'(c * 4)) begin
        rd_d = 16'(offset_q[c]);
        hit = 1'b1;
      end
      for (int k = 0; k < `DCC_THR_KINDS; k++) begin
        if (paddr == `DCC_OFF_THR + 8'((c * `DCC_THR_KINDS + k) * 4)) begin
          rd_d = 16'(thr_q[c][k]); // RULE_11
          hit = 1'b1;
        end
      end
    end
  end

  // Straps are re-sampled every cycle so a board change is followed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_addr <= {`DCC_ADDR_HI, 3'b000};
    end else begin
      slave_addr <= {`DCC_ADDR_HI, addr_strap_high, addr_strap_mid, addr_strap_low}; // RULE_01 RULE_02
    end
  end

  // Clamp follows the pin with one flop of delay and no bus involvement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_clamp <= 2'b00;
    end else begin
      gate_clamp <= safe_operation_input; // RULE_09
    end
  end

  // Clear pulses toward the arithmetic unit and the FIFO
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_q <= '0;
    end else begin
      clr_q <= '{alu_clear: swclr, fifo_clear: swclr}; // RULE_03
    end
  end
  assign alu_clear = clr_q.alu_clear;
  assign fifo_clear = clr_q.fifo_clear;

  // Configuration registers; external references after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_ref_internal <= 1'b0;
      dac_ref_internal <= 1'b0;
      swcfg_q <= '0;
      mask_q <= '0;
      high_voltage_cal_bit <= 2'b00;
    end else if (swclr) begin
      adc_ref_internal <= 1'b0; // RULE_03
      dac_ref_internal <= 1'b0;
      swcfg_q <= '0;
      mask_q <= '0;
      high_voltage_cal_bit <= 2'b00;
    end else if (wr) begin
      if (paddr == `DCC_OFF_HWCFG) begin
        adc_ref_internal <= pwdata[`DCC_BIT_ADC_REFERENCE_SELECT]; // RULE_10
        dac_ref_internal <= pwdata[`DCC_BIT_DAC_REFERENCE_SELECT]; // RULE_10
      end
      if (paddr == `DCC_OFF_SWCFG) swcfg_q <= pwdata[`DCC_WORD_W-1:0];
      if (paddr == `DCC_OFF_MASK) mask_q <= status_t'(pwdata[2:0]);
      if (paddr == `DCC_OFF_HIGH_VOLTAGE_CAL_BIT) high_voltage_cal_bit <= pwdata[1:0];
    end
  end

  dcc_seq #(.CAL_CYCLES(CAL_CYCLES)) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .abort(swclr),
    .cal_start(wr && paddr == `DCC_OFF_AMPCAL),
    .cal_sel(pwdata[1:0]),
    .conv_start(wr && paddr == `DCC_OFF_CONV && pwdata[`DCC_BIT_CONV]),
    .adc_valid(adc_valid),
    .busy(seq_busy),
    .cal_active(amp_cal_active),
    .adc_start(adc_start),
    .cal_done(seq_cal_done),
    .conv_done(seq_conv_done)
  );

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic dir_wr;
    assign dir_wr = wr && paddr == `DCC_OFF_DIRECT + 8'(c * 4);
    // Host supplies a ready-made code; no scaling is applied here
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dac_in_q[c] <= '0;
        dac_out_q[c] <= '0;
      end else if (swclr) begin
        dac_in_q[c] <= '0; // RULE_04
        dac_out_q[c] <= '0;
      end else if (dir_wr) begin
        dac_in_q[c] <= pwdata[DAC_W-1:0]; // RULE_06 RULE_12
        dac_out_q[c] <= pwdata[DAC_W-1:0]; // RULE_06
      end else begin
        if (wr && paddr == `DCC_OFF_DACIN + 8'(c * 4)) dac_in_q[c] <= pwdata[DAC_W-1:0];
        if (xfer) dac_out_q[c] <= dac_in_q[c]; // RULE_05
      end
    end
    assign dac_code[c] = dac_out_q[c];

    for (genvar k = 0; k < `DCC_THR_KINDS; k++) begin : g_thr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          thr_q[c][k] <= '0;
        end else if (swclr) begin
          thr_q[c][k] <= '0; // RULE_04
        end else if (wr && paddr == `DCC_OFF_THR + 8'((c * `DCC_THR_KINDS + k) * 4)) begin
          thr_q[c][k] <= pwdata[ADC_W-1:0]; // RULE_11
        end
      end
    end

    // With the high-voltage cal bit set the conversion is the amplifier offset
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        result_q[c] <= '0;
        offset_q[c] <= '0;
      end else if (swclr) begin
        result_q[c] <= '0;
        offset_q[c] <= '0;
      end else if (conv_take) begin
        if (high_voltage_cal_bit[c]) offset_q[c] <= sense_result[c]; // RULE_08
        else result_q[c] <= sense_result[c];
      end
    end
    // Offset runs never raise a sense alarm
    assign alarm_ev[c] = conv_take && !high_voltage_cal_bit[c] && sense_result[c] > thr_q[c][0];
  end

  assign ev = '{alarm: |alarm_ev, conv_done: seq_conv_done, cal_done: seq_cal_done};

  // Sticky flags: a new event beats a same-cycle clear of any kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aflag_q <= 2'b00;
      status_q <= '0;
    end else if (swclr) begin
      aflag_q <= alarm_ev; // RULE_04
      status_q <= ev;
    end else begin
      aflag_q <= (aflag_q & ~((wr && paddr == `DCC_OFF_AFLAG) ? pwdata[1:0] : 2'b00)) | alarm_ev;
      status_q <= (status_q & ~((wr && paddr == `DCC_OFF_STATUS) ? status_t'(pwdata[2:0]) : '0)) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    psel && !penable;
  endsequence
  sequence apb_done_s;
    psel && penable && pready;
  endsequence

  apb_word_a: assert property (apb_setup_s |=> apb_done_s ##0 prdata[31:16] == 16'h0000) // RULE_13
    else $error("read word not confined to 16 bits or no answer");
  addr_high_a: assert property (##1 slave_addr[6:3] == `DCC_ADDR_HI) // RULE_01
    else $error("fixed address bits wrong");
  strap_order_a: assert property (##1 slave_addr[2:0] == {$past(addr_strap_high), $past(addr_strap_mid),
      $past(addr_strap_low)}) // RULE_02
    else $error("strap bits misplaced");
  clear_cmd_a: assert property (swclr |=> alu_clear && fifo_clear && mask_q == '0 && !adc_ref_internal) // RULE_03
    else $error("clear did not issue commands or reset registers");
  clear_dac_a: assert property (swclr |=> dac_code[0] == '0 && dac_code[1] == '0 && thr_q[1][2] == '0) // RULE_04
    else $error("clear left DAC or threshold state");
  xfer_copy_a: assert property (xfer |=> dac_out_q[0] == $past(dac_in_q[0]) && dac_out_q[1] == $past(dac_in_q[1])) // RULE_05
    else $error("transfer did not copy inputs");
  direct_load_a: assert property (wr && paddr == `DCC_OFF_DIRECT |=> dac_in_q[0] == $past(pwdata[DAC_W-1:0])
      && dac_out_q[0] == dac_in_q[0]) // RULE_06
    else $error("direct load missed input or output");
  cal_start_a: assert property (wr && paddr == `DCC_OFF_AMPCAL && !seq_busy && pwdata[1:0] != 2'b00 |=>
      amp_cal_active == $past(pwdata[1:0])) // RULE_07
    else $error("calibration not started on selected channels");
  offset_rep_a: assert property (conv_take && high_voltage_cal_bit[1] && !swclr |=>
      offset_q[1] == $past(sense_result[1])) // RULE_08
    else $error("offset not reported");
  gate_clamp_a: assert property (safe_operation_input[0] ##1 !safe_operation_input[0] |->
      gate_clamp[0] ##1 !gate_clamp[0]) // RULE_09
    else $error("clamp did not follow safe input");
  ref_sel_a: assert property (wr && paddr == `DCC_OFF_HWCFG |=> dac_ref_internal == $past(pwdata[`DCC_BIT_DAC_REFERENCE_SELECT])) // RULE_10
    else $error("reference select not taken");
  thr_read_a: assert property (apb_setup_s ##0 paddr == `DCC_OFF_THR + 8'h04 && !pwrite |=>
      prdata[ADC_W-1:0] == $past(thr_q[0][1])) // RULE_11
    else $error("threshold readback wrong");
endmodule
`default_nettype wire
